// ===== core/drive_pkg.sv
// Contract
// - Quick stop request fast-stops the motor, then holds in quick-stop-active or goes to switch-on-disabled, not running.
// - Restart from quick-stop-active only after passing through switch-on-disabled.
// - During the fast stop ramp the output stays unlocked and the motor powered.
// - Configuration writes are rejected while quick-stop-active.
// - Stop-then-disable option: after the fast stop ramp go to switch-on-disabled.
// - Stop-and-hold option: stay after ramp until disable voltage, stop key or freewheel.
// - Fault reaction runs the configured response, then enters fault without a command.
// - Fault state keeps power stage disabled, output locked, motor unpowered.
// - Power stage and motor power during fault reaction follow the configured response.
// - Configuration change in switched-on falls back to switch-on-disabled; free in 1, 2, 3, 8.
// - Motor powered only in operation enabled, quick-stop-active while the ramp runs, or fault reaction active when so configured.
// - Fault reset acts on a rising edge of bit 7 once the fault cause is gone.
// - Don't-care bits of the control word are ignored when recognising a command.
// - Status word masked by 006F reads 0040, 0021, 0023, 0027, 0007 per state.
// - Disable operation ramps down first if so selected, otherwise coasts and switches at once.
// - With reference over the channel, enable operation waits for one received reference.
package drive_pkg;

	// ==========================================================
	// Register map (byte addresses of 32-bit words).
	localparam logic [4:0] ADDR_COMMAND = 5'h00;
	localparam logic [4:0] ADDR_STATUS = 5'h04;
	localparam logic [4:0] ADDR_CONFIG = 5'h08;
	localparam logic [4:0] ADDR_REFERENCE = 5'h0c;
	localparam logic [4:0] ADDR_IRQ_STATUS = 5'h10;
	localparam logic [4:0] ADDR_IRQ_MASK = 5'h14;

	// ==========================================================
	// Reset values.
	localparam logic [15:0] COMMAND_RESET = 16'h0000;
	localparam logic [3:0] CONFIG_RESET = 4'h0;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

	// ==========================================================
	// Control word field positions.
	localparam int CW_SWITCH_ON = 0;
	localparam int CW_ENABLE_VOLTAGE = 1;
	localparam int CW_QUICK_STOP = 2;
	localparam int CW_ENABLE_OP = 3;
	localparam int CW_FAULT_RESET = 7;
	localparam int CW_HALT = 8;
	localparam int CW_DIRECTION = 11;
	localparam int CW_USER_LSB = 12;

	// Configuration field positions.
	localparam int CFG_QS_MODE = 0;
	localparam int CFG_DISABLE_RAMP = 1;
	localparam int CFG_REF_CHANNEL = 2;
	localparam int CFG_ERR_POWERED = 3;

	// Interrupt event positions.
	localparam int IRQ_STATE_CHANGE = 0;
	localparam int IRQ_CONFIG_REJECT = 1;
	localparam int IRQ_FAULT = 2;

	// Status word bits outside the state pattern.
	localparam int SW_VOLTAGE = 4;
	localparam int SW_REMOTE = 9;
	localparam int SW_DIRECTION = 15;

	// Status word state patterns (bits 6, 5, 3..0).
	localparam logic [15:0] SW_NOT_READY = 16'h0000;
	localparam logic [15:0] SW_SOD = 16'h0040;
	localparam logic [15:0] SW_RTSO = 16'h0021;
	localparam logic [15:0] SW_SWON = 16'h0023;
	localparam logic [15:0] SW_OPEN = 16'h0027;
	localparam logic [15:0] SW_QSA = 16'h0007;
	localparam logic [15:0] SW_FRA = 16'h000f;
	localparam logic [15:0] SW_FAULT = 16'h0008;
	localparam logic [15:0] SW_FAULT_AFTER_QS = 16'h0028;

	// ==========================================================
	// Timing.
	localparam int CLK_PERIOD_NS = 10;
	localparam int FAST_STOP_TIME_NS = 20000;
	localparam int DISABLE_RAMP_TIME_NS = 30000;
	localparam int FAULT_REACT_TIME_NS = 5000;
	localparam int FAST_STOP_CYCLES = (FAST_STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DISABLE_RAMP_CYCLES = (DISABLE_RAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAULT_REACT_CYCLES = (FAULT_REACT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Operating states, one-hot.
	typedef enum logic [8:0] {
		ST_NOT_READY = 9'h001,
		ST_SOD = 9'h002,
		ST_RTSO = 9'h004,
		ST_SWON = 9'h008,
		ST_OPEN = 9'h010,
		ST_OPSTOP = 9'h020,
		ST_QSA = 9'h040,
		ST_FRA = 9'h080,
		ST_FAULT = 9'h100
	} drive_state_t;

	// Decoded control word.
	typedef struct packed {
		logic shutdown;
		logic switchOn;
		logic enableOp;
		logic disableOp;
		logic disableVoltage;
		logic quickStop;
		logic faultResetEdge;
		logic halt;
		logic reverse;
		logic [3:0] userFunc;
	} drive_cmd_t;

	// Drive outputs towards the power stage.
	typedef struct packed {
		logic powerStageEnable;
		logic outputUnlocked;
		logic motorPowered;
		logic haltActive;
		logic reverse;
		logic [3:0] userFunc;
	} drive_out_t;

endpackage : drive_pkg

// ===== core/control_word_decoder.sv
`timescale 1ns/1ps
module control_word_decoder
	import drive_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [15:0] commandWord,
	output drive_cmd_t cmd
);
	logic faultBit_reg;
	logic faultBit_next;

	// ==========================================================
	// Command recognition looks only at the significant bits.
	always_comb
	begin
		logic [3:0] low;
		low = commandWord[3:0];
		faultBit_next = commandWord[CW_FAULT_RESET];
		cmd.shutdown = (low[2:0] == 3'h6);
		cmd.switchOn = (low[2:0] == 3'h7);
		cmd.enableOp = (low == 4'hf);
		cmd.disableOp = (low == 4'h7);
		cmd.disableVoltage = ~low[CW_ENABLE_VOLTAGE];
		cmd.quickStop = (low[2:1] == 2'h1);
		// Only the rising edge resets; holding the bit high does nothing more.
		cmd.faultResetEdge = commandWord[CW_FAULT_RESET] & ~faultBit_reg;
		cmd.halt = commandWord[CW_HALT];
		cmd.reverse = commandWord[CW_DIRECTION];
		cmd.userFunc = commandWord[15:CW_USER_LSB];
	end

	// Previous fault reset level for the edge detector.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			faultBit_reg <= 1'b0;
		else
			faultBit_reg <= faultBit_next;
	end
endmodule : control_word_decoder

// ===== core/stop_timer.sv
`timescale 1ns/1ps
module stop_timer #(
	parameter int WIDTH = 16
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic start,
	input wire logic abort,
	input wire logic [WIDTH-1:0] loadCount,
	output logic busy,
	output logic done
);
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic busy_reg;
	logic busy_next;
	logic done_reg;
	logic done_next;

	generate
		if (WIDTH < 2)
		begin : bad_width
			$error("stop_timer WIDTH too small");
		end
	endgenerate

	// ==========================================================
	// Down counter; done pulses one cycle after the last counted cycle.
	always_comb
	begin
		count_next = count_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		if (abort)
			busy_next = 1'b0;
		else if (start)
		begin
			count_next = loadCount;
			busy_next = 1'b1;
		end
		else if (busy_reg)
		begin
			if (count_reg <= WIDTH'(1))
			begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end
			else
				count_next = count_reg - WIDTH'(1);
		end
	end

	// Counter registers.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			count_reg <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	assign busy = busy_reg;
	assign done = done_reg;
endmodule : stop_timer

// ===== core/drive_state_machine_control.sv
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
module drive_state_machine_control
	import drive_pkg::*;
#(
	parameter int TIMER_WIDTH = 16
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic faultDetect,
	input wire logic powerPresent,
	input wire logic stopKey,
	input wire logic freewheelStop,
	output drive_out_t driveOut,
	output logic [15:0] drive_status_word,
	output logic irq
);
	localparam logic [TIMER_WIDTH-1:0] FAST_STOP_LOAD = TIMER_WIDTH'(FAST_STOP_CYCLES);
	localparam logic [TIMER_WIDTH-1:0] DISABLE_RAMP_LOAD = TIMER_WIDTH'(DISABLE_RAMP_CYCLES);
	localparam logic [TIMER_WIDTH-1:0] FAULT_REACT_LOAD = TIMER_WIDTH'(FAULT_REACT_CYCLES);

	generate
		if ((2 ** TIMER_WIDTH) <= FAST_STOP_CYCLES || (2 ** TIMER_WIDTH) <= DISABLE_RAMP_CYCLES
			|| (2 ** TIMER_WIDTH) <= FAULT_REACT_CYCLES)
		begin : bad_timer_width
			$error("TIMER_WIDTH cannot hold the stop times");
		end
	endgenerate

	// ==========================================================
	// Declarations.
	drive_state_t state_reg;
	drive_state_t state_next;
	logic [15:0] drive_command_word_reg;
	logic [15:0] drive_command_word_next;
	logic [3:0] config_reg;
	logic [3:0] config_next;
	logic refReceived_reg;
	logic refReceived_next;
	logic fromQs_reg;
	logic fromQs_next;
	logic [2:0] irqStatus_reg;
	logic [2:0] irqStatus_next;
	logic [2:0] irqMask_reg;
	logic [2:0] irqMask_next;
	logic ack_reg;
	logic ack_next;
	logic [31:0] readData_reg;
	logic [31:0] readData_next;
	drive_out_t driveOut_reg;
	drive_out_t driveOut_next;
	logic [15:0] status_reg;
	logic [15:0] status_next;
	drive_cmd_t cmd;
	logic timerStart;
	logic timerAbort;
	logic [TIMER_WIDTH-1:0] timerLoad;
	logic timerBusy;
	logic timerDone;
	logic busTake;
	logic cfgWrite;
	logic cfgAllowed;
	logic refOk;
	logic quick_stop_mode_select;
	logic disable_op_stop_behaviour;

	assign quick_stop_mode_select = config_reg[CFG_QS_MODE];
	assign disable_op_stop_behaviour = config_reg[CFG_DISABLE_RAMP];

	// ==========================================================
	// Helpers.
	function automatic logic [15:0] state_pattern(input drive_state_t st, input logic afterQs);
		unique case (st)
			ST_NOT_READY: state_pattern = SW_NOT_READY;
			ST_SOD: state_pattern = SW_SOD;
			ST_RTSO: state_pattern = SW_RTSO;
			ST_SWON: state_pattern = SW_SWON;
			ST_OPEN, ST_OPSTOP: state_pattern = SW_OPEN;
			ST_QSA: state_pattern = SW_QSA;
			ST_FRA: state_pattern = SW_FRA;
			ST_FAULT: state_pattern = afterQs ? SW_FAULT_AFTER_QS : SW_FAULT;
			default: state_pattern = SW_NOT_READY;
		endcase
	endfunction : state_pattern

	function automatic logic [15:0] merge_bytes(input logic [15:0] old, input logic [31:0] data,
		input logic [3:0] be);
		merge_bytes = old;
		if (be[0])
			merge_bytes[7:0] = data[7:0];
		if (be[1])
			merge_bytes[15:8] = data[15:8];
	endfunction : merge_bytes

	// ==========================================================
	// Submodules.
	control_word_decoder u_decoder (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.commandWord(drive_command_word_reg),
		.cmd(cmd)
	);

	stop_timer #(
		.WIDTH(TIMER_WIDTH)
	) u_timer (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.start(timerStart),
		.abort(timerAbort),
		.loadCount(timerLoad),
		.busy(timerBusy),
		.done(timerDone)
	);

	// ==========================================================
	// Bus handshake: one wait cycle, then the answer stands for one cycle.
	assign busTake = (avs_read | avs_write) & ~ack_reg;
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
	assign cfgWrite = busTake & avs_write & (avs_address == ADDR_CONFIG) & avs_byteenable[0];
	// Configuration may change only while the drive is locked.
	assign cfgAllowed = (state_reg == ST_NOT_READY) || (state_reg == ST_SOD)
		|| (state_reg == ST_RTSO) || (state_reg == ST_SWON)
		|| (state_reg == ST_FAULT);
	assign refOk = ~config_reg[CFG_REF_CHANNEL] | refReceived_reg;

	// ==========================================================
	// Operating state sequencing.
	always_comb
	begin
		state_next = state_reg;
		fromQs_next = fromQs_reg;
		timerStart = 1'b0;
		timerAbort = 1'b0;
		timerLoad = FAST_STOP_LOAD;
		// A detected fault overrides every command outside the fault states.
		if (faultDetect && state_reg != ST_FRA && state_reg != ST_FAULT)
		begin
			state_next = ST_FRA;
			fromQs_next = (state_reg == ST_QSA);
			timerStart = 1'b1;
			timerLoad = FAULT_REACT_LOAD;
		end
		else
		begin
			unique case (state_reg)
				ST_NOT_READY: state_next = ST_SOD;
				ST_SOD:
					if (cmd.shutdown)
						state_next = ST_RTSO;
				ST_RTSO:
					if (cmd.disableVoltage || cmd.quickStop || freewheelStop)
						state_next = ST_SOD;
					else if (cmd.enableOp && powerPresent && refOk)
						state_next = ST_OPEN;
					else if (cmd.switchOn && powerPresent)
						state_next = ST_SWON;
				ST_SWON:
					if (cmd.disableVoltage || cmd.quickStop || freewheelStop)
						state_next = ST_SOD;
					else if (cfgWrite)
						state_next = ST_SOD;
					else if (cmd.shutdown)
						state_next = ST_RTSO;
					else if (cmd.enableOp && refOk)
						state_next = ST_OPEN;
				ST_OPEN:
					if (cmd.disableVoltage || freewheelStop)
						state_next = ST_SOD;
					else if (cmd.quickStop)
					begin
						state_next = ST_QSA;
						timerStart = 1'b1;
						timerLoad = FAST_STOP_LOAD;
					end
					else if (cmd.shutdown)
						state_next = ST_RTSO;
					else if (cmd.disableOp)
					begin
						if (disable_op_stop_behaviour)
						begin
							state_next = ST_OPSTOP;
							timerStart = 1'b1;
							timerLoad = DISABLE_RAMP_LOAD;
						end
						else
							state_next = ST_SWON;
					end
				ST_OPSTOP:
					if (cmd.disableVoltage || freewheelStop)
					begin
						state_next = ST_SOD;
						timerAbort = 1'b1;
					end
					else if (cmd.quickStop)
					begin
						state_next = ST_QSA;
						timerStart = 1'b1;
						timerLoad = FAST_STOP_LOAD;
					end
					else if (timerDone)
						state_next = ST_SWON;
				ST_QSA:
					// Every way out except a fault leads to switch-on-disabled, never back to running.
					if (cmd.disableVoltage || stopKey || freewheelStop)
					begin
						state_next = ST_SOD;
						timerAbort = 1'b1;
					end
					else if (timerDone && !quick_stop_mode_select)
						state_next = ST_SOD;
				ST_FRA:
					if (timerDone)
						state_next = ST_FAULT;
				ST_FAULT:
					if (cmd.faultResetEdge && !faultDetect)
						state_next = ST_SOD;
				default: state_next = ST_SOD;
			endcase
		end
	end

	// ==========================================================
	// Drive outputs and status word, registered.
	always_comb
	begin
		driveOut_next.powerStageEnable = 1'b0;
		driveOut_next.outputUnlocked = 1'b0;
		driveOut_next.motorPowered = 1'b0;
		driveOut_next.haltActive = cmd.halt;
		driveOut_next.reverse = cmd.reverse;
		driveOut_next.userFunc = cmd.userFunc;
		unique case (state_next)
			ST_SWON: driveOut_next.powerStageEnable = 1'b1;
			ST_OPEN:
			begin
				driveOut_next.powerStageEnable = 1'b1;
				driveOut_next.outputUnlocked = 1'b1;
				// Halt keeps the state but removes torque.
				driveOut_next.motorPowered = ~cmd.halt;
			end
			ST_OPSTOP, ST_QSA:
			begin
				driveOut_next.powerStageEnable = 1'b1;
				// Power flows only while the stop ramp is still running.
				driveOut_next.outputUnlocked = timerStart | (timerBusy & ~timerDone
					& ~timerAbort);
				driveOut_next.motorPowered = driveOut_next.outputUnlocked;
			end
			ST_FRA:
			begin
				driveOut_next.powerStageEnable = config_reg[CFG_ERR_POWERED];
				driveOut_next.outputUnlocked = config_reg[CFG_ERR_POWERED];
				driveOut_next.motorPowered = config_reg[CFG_ERR_POWERED];
			end
			default: ; // Fault and every locked state but switched-on stay dark.
		endcase
		status_next = state_pattern(state_next, fromQs_next);
		status_next[SW_VOLTAGE] = powerPresent;
		status_next[SW_REMOTE] = 1'b1;
		status_next[SW_DIRECTION] = cmd.reverse;
	end

	// ==========================================================
	// Register file and interrupt bookkeeping.
	always_comb
	begin
		drive_command_word_next = drive_command_word_reg;
		config_next = config_reg;
		refReceived_next = refReceived_reg;
		irqMask_next = irqMask_reg;
		irqStatus_next = irqStatus_reg;
		ack_next = busTake;
		readData_next = readData_reg;
		if (busTake && avs_write)
		begin
			unique case (avs_address)
				ADDR_COMMAND: drive_command_word_next = merge_bytes(drive_command_word_reg,
					avs_writedata, avs_byteenable);
				ADDR_CONFIG:
					if (cfgAllowed && avs_byteenable[0])
						config_next = avs_writedata[3:0];
				ADDR_REFERENCE: refReceived_next = 1'b1;
				ADDR_IRQ_MASK:
					if (avs_byteenable[0])
						irqMask_next = avs_writedata[2:0];
				default: ;
			endcase
		end
		if (busTake && avs_read)
		begin
			unique case (avs_address)
				ADDR_COMMAND: readData_next = {16'h0000, drive_command_word_reg};
				ADDR_STATUS: readData_next = {16'h0000, status_reg};
				ADDR_CONFIG: readData_next = {28'h0000000, config_reg};
				ADDR_REFERENCE: readData_next = {31'h00000000, refReceived_reg};
				ADDR_IRQ_STATUS:
				begin
					readData_next = {29'h00000000, irqStatus_reg};
					irqStatus_next = 3'h0;
				end
				ADDR_IRQ_MASK: readData_next = {29'h00000000, irqMask_reg};
				default: readData_next = 32'h00000000;
			endcase
		end
		// Events are or-ed in after the read clear so that a set wins.
		irqStatus_next[IRQ_STATE_CHANGE] = irqStatus_next[IRQ_STATE_CHANGE]
			| (state_next != state_reg);
		irqStatus_next[IRQ_CONFIG_REJECT] = irqStatus_next[IRQ_CONFIG_REJECT]
			| (cfgWrite & ~cfgAllowed);
		irqStatus_next[IRQ_FAULT] = irqStatus_next[IRQ_FAULT]
			| (state_next == ST_FRA && state_reg != ST_FRA);
	end

	// State and register flip-flops.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg <= ST_NOT_READY;
			fromQs_reg <= 1'b0;
			drive_command_word_reg <= COMMAND_RESET;
			config_reg <= CONFIG_RESET;
			refReceived_reg <= 1'b0;
			irqMask_reg <= IRQ_MASK_RESET;
			irqStatus_reg <= 3'h0;
			ack_reg <= 1'b0;
			readData_reg <= 32'h00000000;
			driveOut_reg <= '0;
			status_reg <= SW_NOT_READY;
		end
		else
		begin
			state_reg <= state_next;
			fromQs_reg <= fromQs_next;
			drive_command_word_reg <= drive_command_word_next;
			config_reg <= config_next;
			refReceived_reg <= refReceived_next;
			irqMask_reg <= irqMask_next;
			irqStatus_reg <= irqStatus_next;
			ack_reg <= ack_next;
			readData_reg <= readData_next;
			driveOut_reg <= driveOut_next;
			status_reg <= status_next;
		end
	end

	assign avs_readdata = readData_reg;
	assign driveOut = driveOut_reg;
	assign drive_status_word = status_reg;
	assign irq = |(irqStatus_reg & irqMask_reg);
endmodule : drive_state_machine_control

// ===== verif/fieldbus_master.sv
`timescale 1ns/1ps
module fieldbus_master
	import drive_pkg::*;
(
	input wire logic clk_sys,
	input wire logic avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	output logic [4:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable
);
	// Bus starts idle with all lanes enabled.
	initial
	begin
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
	end
	// Reserved command bits are always sent as zero, as a real master would.
	task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= (a == ADDR_COMMAND) ? (d & 32'h0000f98f) : d;
		avs_write <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_writedata <= ~d;
	endtask : bus_wr
	// Read data is taken at the very edge that sees waitrequest low.
	task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_address <= ~a;
	endtask : bus_rd
endmodule : fieldbus_master

// ===== verif/drive_sm_chk.sv
`timescale 1ns/1ps
module drive_sm_chk
	import drive_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic faultDetect,
	input drive_out_t driveOut,
	input logic [15:0] drive_status_word
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	// ==========================================================
	// State view through the documented mask.
	logic [15:0] sm;
	assign sm = drive_status_word & 16'h006f;
	sequence s_hold_idle;
		(sm == 16'h0007) && !driveOut.motorPowered ##1 (sm == 16'h0007);
	endsequence
	sequence s_qsa_left;
		(sm == 16'h0007) ##1 (sm != 16'h0007);
	endsequence
	a_fault_locked: assert property ((sm == 16'h0008 || sm == 16'h0028) |->
		!driveOut.powerStageEnable && !driveOut.outputUnlocked && !driveOut.motorPowered)
		else $error("fault state drives the motor");
	a_motor_states: assert property (driveOut.motorPowered |->
		sm inside {16'h0027, 16'h0007, 16'h000f}) else $error("motor powered in wrong state");
	a_ramp_unlocked: assert property ((sm == 16'h0007 && driveOut.motorPowered) |->
		driveOut.outputUnlocked) else $error("output locked during fast stop");
	// Entering quick stop must start with the ramp running, never with a dark motor.
	a_ramp_powered: assert property ($rose(sm == 16'h0007) |->
		driveOut.outputUnlocked && driveOut.motorPowered) else $error("fast stop began unpowered");
	a_hold_unpowered: assert property (s_hold_idle |-> !driveOut.motorPowered)
		else $error("motor repowered while holding");
	a_qsa_exit: assert property (s_qsa_left |-> sm inside {16'h0040, 16'h000f})
		else $error("quick stop left to a running state");
	a_fault_first: assert property ((faultDetect && !(sm inside {16'h000f, 16'h0008,
		16'h0028})) |-> ##[1:2] sm == 16'h000f) else $error("fault reaction not entered");
	a_fra_transient: assert property ($rose(sm == 16'h000f) |->
		##[400:600] (sm == 16'h0008 || sm == 16'h0028)) else $error("fault reaction stuck");
	a_dir_mirror: assert property (driveOut.reverse == drive_status_word[15])
		else $error("direction outputs disagree");
endmodule : drive_sm_chk
bind drive_state_machine_control drive_sm_chk u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
	.faultDetect(faultDetect), .driveOut(driveOut), .drive_status_word(drive_status_word));

// ===== verif/tb_drive_state_machine_control.sv
`timescale 1ns/1ps
module tb_drive_state_machine_control
	import drive_pkg::*;
;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic faultDetect = 1'b0;
	logic powerPresent = 1'b1;
	logic stopKey = 1'b0;
	logic freewheelStop = 1'b0;
	logic [4:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	drive_out_t driveOut;
	logic [15:0] drive_status_word;
	logic irq;
	logic [31:0] d;
	int err_count = 0;
	int check_count = 0;
	// 100 MHz clock.
	always #5 clk_sys = ~clk_sys;
	drive_state_machine_control u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.faultDetect(faultDetect), .powerPresent(powerPresent), .stopKey(stopKey),
		.freewheelStop(freewheelStop), .driveOut(driveOut),
		.drive_status_word(drive_status_word), .irq(irq));
	fieldbus_master u_master (.clk_sys(clk_sys), .avs_waitrequest(avs_waitrequest),
		.avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));
	// ==========================================================
	// Helpers.
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask : chk
	task automatic st(input logic [15:0] e);
		logic [31:0] r;
		u_master.bus_rd(ADDR_STATUS, r);
		chk("status", {16'h0, e}, r & 32'h0000006f);
	endtask : st
	task automatic cmd(input logic [15:0] w);
		u_master.bus_wr(ADDR_COMMAND, {16'h0, w});
	endtask : cmd
	task automatic cfg(input logic [3:0] c);
		u_master.bus_wr(ADDR_CONFIG, {28'h0, c});
	endtask : cfg
	// Lets n edges pass, then samples away from the edge so registered outputs have settled.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : cyc
	task automatic test_done;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	// A hang costs a mismatch; the whole run needs about 12500 cycles.
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		err_count++;
		test_done();
	end
	// ==========================================================
	// Main sequence.
	initial
	begin
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		u_master.bus_rd(ADDR_STATUS, d);
		chk("status_full", 32'h00000250, d);
		u_master.bus_rd(ADDR_COMMAND, d);
		chk("command_reset", {16'h0, COMMAND_RESET}, d);
		u_master.bus_rd(5'h18, d);
		chk("unmapped", 32'h0, d);
		u_master.bus_rd(ADDR_IRQ_STATUS, d);
		cfg(4'h0);
		cmd(16'h000e);
		st(16'h0021);
		cmd(16'h0007);
		st(16'h0023);
		cfg(4'h0);
		st(16'h0040);
		cmd(16'h0006);
		cmd(16'h000f);
		st(16'h0027);
		cyc(1);
		chk("motor", 32'h1, driveOut.motorPowered);
		cmd(16'h590f);
		cyc(2);
		chk("halt", 32'h1, driveOut.haltActive);
		chk("reverse", 32'h1, driveOut.reverse);
		chk("user_func", 32'h5, driveOut.userFunc);
		chk("halt_motor", 32'h0, driveOut.motorPowered);
		cmd(16'h0007);
		st(16'h0023);
		cmd(16'h000f);
		cmd(16'h0002);
		st(16'h0007);
		cyc(1);
		chk("fast_stop_power", 32'h3, {driveOut.outputUnlocked, driveOut.motorPowered});
		// Rejected configuration write raises an event that stays masked until its mask bit is set.
		cfg(4'h1);
		u_master.bus_rd(ADDR_CONFIG, d);
		chk("config_kept", 32'h0, d & 32'hf);
		cyc(1);
		chk("irq_masked", 32'h0, irq);
		u_master.bus_wr(ADDR_IRQ_MASK, 32'h2);
		cyc(1);
		chk("irq_raised", 32'h1, irq);
		u_master.bus_rd(ADDR_IRQ_STATUS, d);
		chk("irq_reject", 32'h2, d & 32'h2);
		cyc(2);
		chk("irq_cleared", 32'h0, irq);
		cyc(2100);
		st(16'h0040);
		// Stop-and-hold left by each of its three exits in turn.
		cfg(4'h1);
		for (int k = 0; k < 3; k++)
		begin
			cmd(16'h0006);
			cmd(16'h000f);
			cmd(16'h0002);
			cyc(2100);
			st(16'h0007);
			chk("hold_motor", 32'h0, driveOut.motorPowered);
			cmd(16'h000f);
			st(16'h0007);
			if (k == 0)
				cmd(16'h0000);
			stopKey <= (k == 1);
			freewheelStop <= (k == 2);
			cyc(3);
			st(16'h0040);
			stopKey <= 1'b0;
			freewheelStop <= 1'b0;
		end
		// Reference over the channel, then a ramped disable operation.
		cfg(4'h6);
		cmd(16'h0006);
		cmd(16'h000f);
		st(16'h0023);
		u_master.bus_wr(ADDR_REFERENCE, 32'h1);
		cmd(16'h0006);
		cmd(16'h000f);
		st(16'h0027);
		cmd(16'h0007);
		cyc(20);
		chk("ramp_motor", 32'h1, driveOut.motorPowered);
		cyc(3100);
		st(16'h0023);
		// Fault with power kept through the reaction, then reset by edge only.
		cfg(4'h8);
		cmd(16'h0006);
		cmd(16'h000f);
		faultDetect <= 1'b1;
		cyc(2);
		chk("fra", 32'h000f, drive_status_word & 16'h006f);
		chk("fra_motor", 32'h1, driveOut.motorPowered);
		cmd(16'h0080);
		cyc(600);
		st(16'h0008);
		chk("fault_stage", 32'h0, driveOut.powerStageEnable);
		faultDetect <= 1'b0;
		cyc(3);
		st(16'h0008);
		cmd(16'h0000);
		cmd(16'h0080);
		st(16'h0040);
		test_done();
	end
endmodule : tb_drive_state_machine_control
